// file: hw/dsl_pkg.sv
// Constants for the dynamic safety loop supervisor.
// Assumes a single 20 MHz clock shared by every file that uses it.
package dsl_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // Wave half period: 2 ms, i.e. 250 Hz full wave, 500 checks per second
  localparam int unsigned HALF_PERIOD_US = 2000;
  localparam int unsigned HALF_PERIOD_CYC = (HALF_PERIOD_US * (CLK_HZ / 1000000));
  // Returned edge must arrive before this point of the half period
  localparam int unsigned CHECK_AT_US = 1800;
  localparam int unsigned CHECK_AT_CYC = (CHECK_AT_US * (CLK_HZ / 1000000));
  // Least reset contact closure, rounded up
  localparam int unsigned RESET_CLOSE_MS = 80;
  localparam int unsigned RESET_CLOSE_CYC = RESET_CLOSE_MS * (CLK_HZ / 1000);
  // Good half periods counted before the next good one makes the loop healthy
  localparam int unsigned GOOD_NEEDED = 4;
  localparam int unsigned CNT_W = 24;

  // APB map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam int unsigned CTRL_INFO_MODE_BIT = 0;
  localparam logic CTRL_RESET_VAL = 1'b0;
  localparam logic [3:0] IRQ_MASK_RESET_VAL = 4'h0;
  // Interrupt event bit positions
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_ARMED = 1;
  localparam int unsigned EV_HEALTHY = 2;
  localparam int unsigned EV_RESET_REJECT = 3;

  typedef enum logic [1:0] {
    DSL_RST_IDLE,
    DSL_RST_CLOSED,
    DSL_RST_LONG
  } dsl_rst_state_t;
endpackage

// file: hw/dsl_sync.sv
// Two-flop synchroniser for asynchronous pins.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/1ps
module dsl_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // dsl_sync

// file: hw/dsl_supervisor.sv
// Dynamic safety loop supervisor: wave generator, return checker, reset logic, outputs, APB.
// Assumes loop, strap and contact pins are asynchronous; APB master on pclk.
//
// Notes on behaviour
// (RULE1) Drive a continuous square wave out and receive it back through the chain.
// (RULE2) Each sensor inverts the wave when intact, blocks it when broken.
// (RULE3) Check the returned wave at least 200 times per second, every pulse.
// (RULE4) Parity strap high expects even inversions; open expects odd.
// (RULE5) Missing returned wave opens both safety outputs at once.
// (RULE6) Wrong polarity or late return is a fault and opens outputs.
// (RULE7) Manual reset needs contact close then open with loop healthy.
// (RULE8) Reset closures shorter than 80 ms are ignored.
// (RULE9) Auto reset link tied high: outputs close once loop is valid.
// (RULE10) Reset is only allowed while the feedback path is closed.
// (RULE11) Two safety outputs switch together: closed only when reset and healthy.
// (RULE12) Info mode 1: info output low when not reset, high when reset.
// (RULE13) Info mode 2: info output high only when healthy but not reset.
// (RULE14) Outputs close within 40 ms of activation conditions.
// (RULE15) Outputs open within 38 ms of loop loss.
// (RULE16) After power-up or fault, stay not reset until a new valid reset.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module dsl_supervisor #(
  parameter int unsigned HALF_CYC = dsl_pkg::HALF_PERIOD_CYC,
  parameter int unsigned CHECK_CYC = dsl_pkg::CHECK_AT_CYC,
  parameter int unsigned CLOSE_CYC = dsl_pkg::RESET_CLOSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic loop_wave_out,
  input wire logic loop_wave_in,
  input wire logic parity_select,
  input wire logic reset_contact_in,
  input wire logic auto_reset_link,
  output logic safety_out_a,
  output logic safety_out_b,
  output logic info_output,
  output logic irq
);
  // Refuse timings that the counters cannot hold
  if (HALF_CYC < 2 || HALF_CYC > (1 << dsl_pkg::CNT_W)) begin : g_bad_half
    $error("Half period out of range");
  end
  if (CHECK_CYC == 0 || CHECK_CYC >= HALF_CYC) begin : g_bad_check
    $error("Check point beyond half period");
  end
  if (CLOSE_CYC == 0 || CLOSE_CYC >= (1 << dsl_pkg::CNT_W)) begin : g_bad_close
    $error("Counter too narrow");
  end
  if (dsl_pkg::GOOD_NEEDED < 1 || dsl_pkg::GOOD_NEEDED > 7) begin : g_bad_good
    $error("Good count out of range");
  end

  localparam logic [dsl_pkg::CNT_W-1:0] HALF_LAST = dsl_pkg::CNT_W'(HALF_CYC - 1);
  localparam logic [dsl_pkg::CNT_W-1:0] CHECK_AT = dsl_pkg::CNT_W'(CHECK_CYC);
  localparam logic [dsl_pkg::CNT_W-1:0] CLOSE_MIN = dsl_pkg::CNT_W'(CLOSE_CYC);
  localparam logic [2:0] GOOD_MAX = 3'(dsl_pkg::GOOD_NEEDED);

  logic [3:0] pins_s;

  dsl_sync #(
    .WIDTH(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({auto_reset_link, reset_contact_in, parity_select, loop_wave_in}),
    .sync_out(pins_s)
  );

  wire logic wave_in_s = pins_s[0];
  wire logic parity_s = pins_s[1];
  wire logic contact_s = pins_s[2];
  wire logic auto_s = pins_s[3];

  typedef struct packed {
    logic [dsl_pkg::CNT_W-1:0] phase_cnt;
    logic wave;
    logic prev_in;
    logic got_edge;
    logic [2:0] good_cnt;
    logic healthy;
    logic is_reset;
    dsl_pkg::dsl_rst_state_t rst_st;
    logic [dsl_pkg::CNT_W-1:0] close_cnt;
    logic info_mode;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
    logic out_on;
    logic info;
  } dsl_state_t;

  dsl_state_t s_q, s_d;

  function automatic logic expected_level(input logic wave, input logic even);
    return even ? wave : ~wave;
  endfunction

  // One decoder shared by writes and error response; the read mux decodes with its own case
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    return addr_is(addr, dsl_pkg::ADDR_CTRL) || addr_is(addr, dsl_pkg::ADDR_STATUS) ||
           addr_is(addr, dsl_pkg::ADDR_IRQ_STAT) || addr_is(addr, dsl_pkg::ADDR_IRQ_MASK);
  endfunction

  // Write-one-to-clear; a new event wins over the clear
  function automatic logic [3:0] w1c_next(input logic [3:0] stat, input logic clr_en, input logic [3:0] clr,
                                          input logic [3:0] set);
    logic [3:0] kept;
    kept = clr_en ? (stat & ~clr) : stat;
    return kept | set;
  endfunction

  // Mode 1 reports reset state; mode 2 flags a restart block
  function automatic logic info_level(input logic mode2, input logic healthy, input logic armed);
    if (mode2) begin
      return healthy && !armed;
    end
    return armed;
  endfunction

  logic edge_seen;
  logic edge_ok;
  logic bad;
  logic acc;
  logic wr;
  logic [3:0] ev;

  always_comb begin
    s_d = s_q;
    ev = 4'h0;
    bad = 1'b0;
    acc = psel && penable;
    wr = acc && pwrite;

    // Wave generation and per-half check [RULE1] [RULE3]
    s_d.prev_in = wave_in_s;
    edge_seen = wave_in_s != s_q.prev_in;
    edge_ok = (wave_in_s == expected_level(s_q.wave, parity_s)) && (s_q.phase_cnt < CHECK_AT);
    if (edge_seen) begin
      // Edge must carry the level matching the expected inversion count [RULE4] [RULE6]
      if (edge_ok) begin
        s_d.got_edge = 1'b1;
      end else begin
        bad = 1'b1;
        s_d.healthy = 1'b0;
        s_d.good_cnt = 3'h0;
      end
    end
    if (s_q.phase_cnt == HALF_LAST) begin
      s_d.phase_cnt = '0;
      s_d.wave = ~s_q.wave;
      s_d.got_edge = 1'b0;
      // Absent or late returned edge means loop lost [RULE5] [RULE15]
      // Old flag on purpose: the next one was just cleared for the new half
      if (!s_q.got_edge || bad) begin
        s_d.healthy = 1'b0;
        s_d.good_cnt = 3'h0;
      end else if (s_q.good_cnt == GOOD_MAX) begin
        s_d.healthy = 1'b1;
      end else begin
        s_d.good_cnt = s_q.good_cnt + 3'h1;
      end
    end else begin
      s_d.phase_cnt = s_q.phase_cnt + 1'b1;
    end
    if (s_q.healthy && !s_d.healthy) begin
      ev[dsl_pkg::EV_FAULT] = 1'b1;
    end
    if (!s_q.healthy && s_d.healthy) begin
      ev[dsl_pkg::EV_HEALTHY] = 1'b1;
    end

    // Loss of loop drops the reset state; new reset needed [RULE16]
    if (!s_d.healthy) begin
      s_d.is_reset = 1'b0;
    end

    // Reset contact tracking; feedback contacts sit in series with it [RULE10]
    case (s_q.rst_st)
      dsl_pkg::DSL_RST_IDLE: begin
        s_d.close_cnt = '0;
        if (contact_s) begin
          s_d.rst_st = dsl_pkg::DSL_RST_CLOSED;
        end
      end
      dsl_pkg::DSL_RST_CLOSED: begin
        s_d.close_cnt = s_q.close_cnt + 1'b1;
        if (!contact_s) begin
          // Too short a closure is disregarded [RULE8]
          s_d.rst_st = dsl_pkg::DSL_RST_IDLE;
          ev[dsl_pkg::EV_RESET_REJECT] = 1'b1;
        end else if (s_d.close_cnt >= CLOSE_MIN) begin
          s_d.rst_st = dsl_pkg::DSL_RST_LONG;
        end
      end
      dsl_pkg::DSL_RST_LONG: begin
        if (!contact_s) begin
          s_d.rst_st = dsl_pkg::DSL_RST_IDLE;
          // Release after a long enough closure arms the outputs [RULE7]
          if (s_d.healthy && !auto_s) begin
            s_d.is_reset = 1'b1;
          end
        end
      end
      default: s_d.rst_st = dsl_pkg::DSL_RST_IDLE;
    endcase

    // Automatic reset with the feedback path closed [RULE9] [RULE10]
    if (auto_s && contact_s && s_d.healthy) begin
      s_d.is_reset = 1'b1;
    end
    if (!s_q.is_reset && s_d.is_reset) begin
      ev[dsl_pkg::EV_ARMED] = 1'b1;
    end

    // Both outputs from one flop; well inside 40 ms and 38 ms [RULE11] [RULE14] [RULE15]
    s_d.out_on = s_d.is_reset && s_d.healthy;
    // Information output modes [RULE12] [RULE13]
    s_d.info = info_level(s_q.info_mode, s_d.healthy, s_d.is_reset);

    // APB registers; writes to unmapped addresses are refused
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        dsl_pkg::ADDR_CTRL: s_d.rdata = {31'h0, s_q.info_mode};
        dsl_pkg::ADDR_STATUS: s_d.rdata = {25'h0,
                                          parity_s,
                                          auto_s,
                                          contact_s,
                                          wave_in_s,
                                          s_q.out_on,
                                          s_q.is_reset,
                                          s_q.healthy};
        dsl_pkg::ADDR_IRQ_STAT: s_d.rdata = {28'h0, s_q.irq_stat};
        dsl_pkg::ADDR_IRQ_MASK: s_d.rdata = {28'h0, s_q.irq_mask};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr && addr_is(paddr, dsl_pkg::ADDR_CTRL)) begin
      s_d.info_mode = pwdata[dsl_pkg::CTRL_INFO_MODE_BIT];
    end
    if (wr && addr_is(paddr, dsl_pkg::ADDR_IRQ_MASK)) begin
      s_d.irq_mask = pwdata[3:0];
    end
    s_d.irq_stat = w1c_next(s_q.irq_stat, wr && addr_is(paddr, dsl_pkg::ADDR_IRQ_STAT), pwdata[3:0], ev);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{
        phase_cnt: '0,
        wave: 1'b0,
        prev_in: 1'b0,
        got_edge: 1'b0,
        good_cnt: 3'h0,
        healthy: 1'b0,
        is_reset: 1'b0,
        rst_st: dsl_pkg::DSL_RST_IDLE,
        close_cnt: '0,
        info_mode: dsl_pkg::CTRL_RESET_VAL,
        irq_stat: 4'h0,
        irq_mask: dsl_pkg::IRQ_MASK_RESET_VAL,
        rdata: 32'h0000_0000,
        out_on: 1'b0,
        info: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign loop_wave_out = s_q.wave;
  assign safety_out_a = s_q.out_on;
  assign safety_out_b = s_q.out_on;
  assign info_output = s_q.info;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = acc && !addr_mapped(paddr);
endmodule // dsl_supervisor

// file: tb/dsl_chain.sv
// Model of the sensor chain on the loop.
// Assumes the wave comes from the supervisor on pclk.
`timescale 1ns/1ps
module dsl_chain (
  input wire logic pclk,
  input wire logic wave_fwd,
  input wire logic [2:0] n_inv,
  input wire logic broken,
  output logic wave_back = 1'b0
);
  // Broken sensor stops forwarding; otherwise the wave is inverted when n_inv is odd
  always @(posedge pclk) wave_back <= broken ? 1'b0 : wave_fwd ^ n_inv[0];
endmodule // dsl_chain

// file: tb/dsl_props.sv
// Checker of the supervisor ports.
// Assumes the package constants and one pclk domain.
`timescale 1ns/1ps
module dsl_props #(
  parameter int unsigned H = dsl_pkg::HALF_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic loop_wave_out,
  input wire logic loop_wave_in,
  input wire logic parity_select,
  input wire logic reset_contact_in,
  input wire logic auto_reset_link,
  input wire logic safety_out_a,
  input wire logic safety_out_b,
  input wire logic info_output,
  input wire logic irq
);
  logic mode_q, wo_q, wi_q;
  logic [23:0] per_q, stk_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mode_q, wo_q, wi_q, per_q, stk_q} <= '0;
    end else begin
      if (psel && penable && pwrite && paddr == dsl_pkg::ADDR_CTRL) mode_q <= pwdata[0];
      wo_q <= loop_wave_out;
      wi_q <= loop_wave_in;
      per_q <= (loop_wave_out != wo_q) ? 24'h0 : per_q + 24'h1;
      // Saturate so a dead loop cannot wrap the count
      stk_q <= (loop_wave_in != wi_q) ? 24'h0 : (stk_q[23] ? stk_q : stk_q + 24'h1);
    end
  end
  safety_pair_a: assert property (safety_out_a == safety_out_b) else $error("safety outputs differ");
  wave_slow_a: assert property (per_q <= H) else $error("wave half too long");
  wave_fast_a: assert property (loop_wave_out != wo_q |-> per_q >= H - 2) else $error("wave half short");
  loss_open_a: assert property (stk_q > 2 * H + 16 |-> !safety_out_a) else $error("dead loop kept on");
  info_one_a: assert property (safety_out_a && $past(safety_out_a) && !mode_q && !$past(mode_q) |-> info_output)
    else $error("info low while reset");
  info_two_a: assert property (safety_out_a && $past(safety_out_a) && mode_q && $past(mode_q) |-> !info_output)
    else $error("info high while reset");
  arm_cause_a: assert property ($rose(safety_out_a) |-> (auto_reset_link ? reset_contact_in : !reset_contact_in))
    else $error("outputs closed without reset");
  apb_ready_a: assert property (psel |-> pready) else $error("pready low");
  apb_err_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  c_on: cover property ($rose(safety_out_a));
  c_off: cover property ($fell(safety_out_a));
  c_err: cover property (pslverr);
endmodule // dsl_props
bind dsl_supervisor dsl_props #(.H(HALF_CYC)) i_dsl_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .loop_wave_out, .loop_wave_in, .parity_select, .reset_contact_in,
  .auto_reset_link, .safety_out_a, .safety_out_b, .info_output, .irq);

// file: tb/testbench.sv
// Self-checking bench of the supervisor with a sensor chain model.
// Assumes shortened wave and closure counts passed to the design to keep the run short.
`timescale 1ns/1ps
`define CHK(o, e) begin total_checks++; if ((o) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h exp %h", $time, o, e); end end
module testbench;
  localparam int H = 400;
  localparam int CK = 360;
  localparam int CL = 2000;
  logic exp_err;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, smp = 0;
  logic parity_select = 1, reset_contact_in = 0, auto_reset_link = 1, broken = 0;
  logic [7:0] paddr = 8'h00, rnd = 8'h50;
  logic [31:0] pwdata = 32'h0, prdata, ev, ov;
  logic pready, pslverr, loop_wave_out, loop_wave_in, safety_out_a, safety_out_b, info_output, irq;
  logic [2:0] n_inv = 3'h0;
  logic [31:0] exp_q[$];
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #25 pclk = ~pclk;
  dsl_supervisor #(.HALF_CYC(H), .CHECK_CYC(CK), .CLOSE_CYC(CL)) i_dsl_supervisor (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .loop_wave_out, .loop_wave_in, .parity_select, .reset_contact_in, .auto_reset_link,
    .safety_out_a, .safety_out_b, .info_output, .irq);
  dsl_chain i_dsl_chain (.pclk, .wave_fwd(loop_wave_out), .n_inv, .broken, .wave_back(loop_wave_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Reads note their expected word; writes note nothing
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  // Output order: safety a, safety b, info, irq
  task automatic probe(input logic [3:0] e);
    exp_q.push_back({28'h0, e});
    @(posedge pclk) smp <= 1'b1;
    @(posedge pclk) smp <= 1'b0;
  endtask
  always @(posedge pclk) begin
    if (smp || (psel && penable && pready === 1'b1 && !pwrite)) begin
      ev = exp_q.pop_front();
      ov = smp ? {28'h0, safety_out_a, safety_out_b, info_output, irq} : prdata;
      `CHK(ov, ev)
    end
    if (psel && penable && pready === 1'b1) begin
      exp_err = !(paddr inside {dsl_pkg::ADDR_CTRL, dsl_pkg::ADDR_STATUS,
                                dsl_pkg::ADDR_IRQ_STAT, dsl_pkg::ADDR_IRQ_MASK});
      `CHK(pslverr, exp_err)
    end
  end
  // Ceiling about two and a half times the scripted waits
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    waitc(12);
    presetn <= 1'b1;
    waitc(7 * H);
    probe(4'b0000);
    reset_contact_in <= 1'b1;
    waitc(40);
    probe(4'b1110);
    apb(1, dsl_pkg::ADDR_IRQ_MASK, 32'h1, 0);
    apb(0, dsl_pkg::ADDR_IRQ_MASK, 0, 32'h1);
    apb(1, dsl_pkg::ADDR_CTRL, 32'h1, 0);
    apb(1, dsl_pkg::ADDR_IRQ_STAT, 32'hf, 0);
    probe(4'b1100);
    rnd = lfsr(rnd);
    apb(1, 8'h40, {24'h0, rnd}, 0);
    apb(0, 8'h40, 0, 0);
    broken <= 1'b1;
    waitc(2 * H + 100);
    probe(4'b0001);
    apb(1, dsl_pkg::ADDR_IRQ_MASK, 32'h0, 0);
    probe(4'b0000);
    {broken, n_inv} <= {1'b0, 3'h1};
    waitc(7 * H);
    probe(4'b0000);
    parity_select <= 1'b0;
    waitc(7 * H);
    probe(4'b1100);
    {auto_reset_link, reset_contact_in, broken} <= 3'b001;
    waitc(2 * H + 100);
    broken <= 1'b0;
    waitc(7 * H);
    probe(4'b0010);
    rnd = lfsr(rnd);
    reset_contact_in <= 1'b1;
    waitc(1000 + int'(rnd));
    reset_contact_in <= 1'b0;
    waitc(40);
    probe(4'b0010);
    reset_contact_in <= 1'b1;
    waitc(CL + 100);
    probe(4'b0010);
    reset_contact_in <= 1'b0;
    waitc(40);
    probe(4'b1100);
    end_sim();
  end
endmodule // testbench
